// *** rtl/desc_walker_pkg.sv ***
package desc_walker_pkg;

	// ==========================================
	// Register map (byte addresses)
	localparam logic [7:0] CTL_ADDR = 8'h00;
	localparam logic [7:0] STS_ADDR = 8'h04;
	localparam logic [7:0] CFG_ADDR = 8'h08;
	localparam logic [7:0] DPTRL_ADDR = 8'h0c;
	localparam logic [7:0] DPTRH_ADDR = 8'h10;
	localparam logic [7:0] NPTRL_ADDR = 8'h14;
	localparam logic [7:0] NPTRH_ADDR = 8'h18;

	// ==========================================
	// Control, status and config bit positions
	localparam int CTL_RUN_BIT = 0;
	localparam int STS_HALT_BIT = 0;
	localparam int STS_FIN_BIT = 1;
	localparam int STS_CHAIN_BIT = 2;
	localparam int STS_ERR_BIT = 3;
	localparam int CFG_NSPL_BIT = 0;
	localparam int CFG_NSPH_BIT = 1;
	localparam int CFG_NCL_BIT = 2;
	localparam int CFG_NCH_BIT = 3;
	localparam int CFG_POL_LO = 4;

	// ==========================================
	// Descriptor layout
	localparam int DESC_WORDS = 8;
	localparam int DW_NEXT_LO = 6;
	localparam int DW_NEXT_HI = 7;
	localparam int DESCRIPTOR_STATUS_FIELD_LO = 27;
	localparam int IOF_BIT = 26;
	localparam int LST_BIT = 25;
	localparam logic [3:0] STS_BYTE_EN = 4'h8;
	localparam logic [1:0] DESCRIPTOR_STATUS_FIELD_UNPROC = 2'h0;
	localparam logic [1:0] DESCRIPTOR_STATUS_FIELD_DONE = 2'h1;
	localparam logic [1:0] DESCRIPTOR_STATUS_FIELD_ERROR = 2'h3;
	localparam logic [2:0] DW_ADDR_SHIFT = 3'h2;

	// Status check policy
	localparam logic [1:0] POL_PROCESS = 2'h0;
	localparam logic [1:0] POL_SKIP = 2'h1;
	localparam logic [1:0] POL_ABORT = 2'h2;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_FETCH = 6'h02,
		ST_WAIT = 6'h04,
		ST_EVAL = 6'h08,
		ST_WBACK = 6'h10,
		ST_NEXT = 6'h20
	} walk_e;

	// Memory request toward host memory
	typedef struct packed {
		logic valid;
		logic write;
		logic [63:0] addr;
		logic [31:0] data;
		logic [3:0] be;
	} mem_req_s;

	// Read data returning from host memory
	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} mem_rsp_s;

endpackage

// *** rtl/desc_walker.sv ***
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
// Behaviour
// - Processing starts only while error flag clear; setting run when idle starts it.
// - Non-zero low pointer write starts processing unless its disable bit is set.
// - Non-zero high pointer write starts processing unless its disable bit is set.
// - Low and high pointers form a 64-bit address; descriptor fetched there.
// - Any start sets the run bit.
// - Status write-back uses byte enables touching only byte 3 of word 0.
// - Non-zero next address after completion, last flag clear, fetches that descriptor.
// - Zero next address or last flag, without chaining, stops processing.
// - Halting sets halt flag and clears run.
// - Pointers keep last fetched descriptor; run again refetches it.
// - Non-zero status with process policy: descriptor handled normally.
// - Non-zero status with skip policy: no write-back, follow next fields.
// - Non-zero status with abort policy: abort and flag error.
// - Clean finish with interrupt-on-finish sets finished flag.
// - At list end with next-list non-zero: copy, zero, set chain, continue.
// - Next-list writes while running only update the value.
// - Non-zero next-list write while stopped and error clear performs chaining unless its disable bit is set.
// - Disable bits choose which next-list halves are tested for chaining.
// - Both disable bits set: never chain.
// - Status is bits 28:27 of word 0: 0 unprocessed, 1 done, 3 error.
// - Next address is words 6 (low) and 7 (high).
// - Interrupt-on-finish flag is bit 26 of word 0.
module desc_walker
	import desc_walker_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Write enable
	input wire logic [7:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte selects
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	output logic wb_err_o, // Unmapped address
	output mem_req_s mem_req, // Request to host memory
	input wire logic mem_ready, // Memory accepts request
	input mem_rsp_s mem_rsp // Read data words, in order
);

	// ==========================================
	// State
	typedef struct packed {
		walk_e st;
		logic run;
		logic halt;
		logic fin;
		logic chain;
		logic err;
		logic [5:0] cfg;
		logic [31:0] dptr_lo;
		logic [31:0] dptr_hi;
		logic [31:0] nptr_lo;
		logic [31:0] nptr_hi;
		logic [2:0] cnt;
		logic [31:0] w0;
		logic [31:0] next_lo;
		logic [31:0] next_hi;
		logic ack;
		logic bus_err;
		logic [31:0] rdata;
		mem_req_s req;
	} state_s;

	state_s s_r, s_nxt;

	// Chain test per disable bits
	function automatic logic chain_ok(input logic ncl, input logic nch,
			input logic [31:0] lo, input logic [31:0] hi);
		chain_ok = ((!ncl) && (lo != '0)) || ((!nch) && (hi != '0));
	endfunction

	// Sel-masked write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				m[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		merge = m;
	endfunction

	logic wr;
	logic rd;
	logic [31:0] wval;
	logic [1:0] pol;
	logic [1:0] descriptor_status_field;

	// Held request is not taken again in the cycle its answer stands
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !s_r.ack && !s_r.bus_err;
	assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !s_r.ack && !s_r.bus_err;
	assign pol = s_r.cfg[CFG_POL_LO +: 2];
	assign descriptor_status_field = s_r.w0[DESCRIPTOR_STATUS_FIELD_LO +: 2];

	// ==========================================
	// Next state
	always_comb begin
		logic start;
		logic do_chain;
		start = 1'b0;
		do_chain = 1'b0;
		s_nxt = s_r;
		s_nxt.ack = 1'b0;
		s_nxt.bus_err = 1'b0;
		wval = '0;

		// Bus slave: answers one cycle after request
		if ((wr || rd) && !s_r.ack) begin
			s_nxt.ack = 1'b1;
			unique case (wb_adr_i)
				CTL_ADDR: s_nxt.rdata = {31'h0, s_r.run};
				STS_ADDR: s_nxt.rdata = {28'h0, s_r.err, s_r.chain, s_r.fin, s_r.halt};
				CFG_ADDR: s_nxt.rdata = {26'h0, s_r.cfg};
				DPTRL_ADDR: s_nxt.rdata = s_r.dptr_lo;
				DPTRH_ADDR: s_nxt.rdata = s_r.dptr_hi;
				NPTRL_ADDR: s_nxt.rdata = s_r.nptr_lo;
				NPTRH_ADDR: s_nxt.rdata = s_r.nptr_hi;
				default: begin
					s_nxt.ack = 1'b0;
					s_nxt.bus_err = 1'b1;
					s_nxt.rdata = '0;
				end
			endcase
		end

		if (wr) begin
			unique case (wb_adr_i)
				CTL_ADDR: begin
					wval = merge({31'h0, s_r.run}, wb_dat_i, wb_sel_i);
					if (wval[CTL_RUN_BIT] && !s_r.run) begin
						start = 1'b1;
					end
				end
				STS_ADDR: begin
					// Write one to clear
					wval = merge('0, wb_dat_i, wb_sel_i);
					s_nxt.halt = s_r.halt & ~wval[STS_HALT_BIT];
					s_nxt.fin = s_r.fin & ~wval[STS_FIN_BIT];
					s_nxt.chain = s_r.chain & ~wval[STS_CHAIN_BIT];
					s_nxt.err = s_r.err & ~wval[STS_ERR_BIT];
				end
				CFG_ADDR: begin
					wval = merge({26'h0, s_r.cfg}, wb_dat_i, wb_sel_i);
					s_nxt.cfg = wval[5:0];
				end
				DPTRL_ADDR: begin
					wval = merge(s_r.dptr_lo, wb_dat_i, wb_sel_i);
					s_nxt.dptr_lo = wval;
					if (wval != '0 && !s_r.cfg[CFG_NSPL_BIT]) begin
						start = 1'b1;
					end
				end
				DPTRH_ADDR: begin
					wval = merge(s_r.dptr_hi, wb_dat_i, wb_sel_i);
					s_nxt.dptr_hi = wval;
					if (wval != '0 && !s_r.cfg[CFG_NSPH_BIT]) begin
						start = 1'b1;
					end
				end
				NPTRL_ADDR: begin
					wval = merge(s_r.nptr_lo, wb_dat_i, wb_sel_i);
					s_nxt.nptr_lo = wval;
					if (!s_r.run && !s_r.err && wval != '0 && !s_r.cfg[CFG_NCL_BIT]) begin
						do_chain = 1'b1;
					end
				end
				NPTRH_ADDR: begin
					wval = merge(s_r.nptr_hi, wb_dat_i, wb_sel_i);
					s_nxt.nptr_hi = wval;
					if (!s_r.run && !s_r.err && wval != '0 && !s_r.cfg[CFG_NCH_BIT]) begin
						do_chain = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// Software chaining while stopped
		if (do_chain) begin
			s_nxt.dptr_lo = s_nxt.nptr_lo;
			s_nxt.dptr_hi = s_nxt.nptr_hi;
			s_nxt.nptr_lo = '0;
			s_nxt.nptr_hi = '0;
			s_nxt.chain = 1'b1;
			start = 1'b1;
		end

		// Start only from idle with error clear
		if (start && s_r.st == ST_IDLE && !s_r.err) begin
			s_nxt.run = 1'b1;
			s_nxt.halt = 1'b0;
			s_nxt.st = ST_FETCH;
		end

		// Descriptor walk
		unique case (s_r.st)
			ST_IDLE: begin
			end
			ST_FETCH: begin
				// Burst read of the whole descriptor at the 64-bit pointer
				s_nxt.req.valid = 1'b1;
				s_nxt.req.write = 1'b0;
				s_nxt.req.addr = {s_r.dptr_hi, s_r.dptr_lo};
				s_nxt.req.be = '1;
				s_nxt.req.data = '0;
				s_nxt.cnt = '0;
				if (s_r.req.valid && mem_ready) begin
					s_nxt.req.valid = 1'b0;
					s_nxt.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (mem_rsp.valid) begin
					s_nxt.cnt = s_r.cnt + 3'h1;
					if (s_r.cnt == 3'h0) begin
						s_nxt.w0 = mem_rsp.data;
					end
					if (s_r.cnt == 3'(DW_NEXT_LO)) begin
						s_nxt.next_lo = mem_rsp.data;
					end
					if (s_r.cnt == 3'(DW_NEXT_HI)) begin
						s_nxt.next_hi = mem_rsp.data;
						s_nxt.st = ST_EVAL;
					end
				end
			end
			ST_EVAL: begin
				if (descriptor_status_field != DESCRIPTOR_STATUS_FIELD_UNPROC && pol == POL_SKIP) begin
					// Skipped descriptor: follow its next fields directly
					s_nxt.dptr_lo = s_r.next_lo;
					s_nxt.dptr_hi = s_r.next_hi;
					s_nxt.st = ST_FETCH;
				end else if (descriptor_status_field != DESCRIPTOR_STATUS_FIELD_UNPROC && pol == POL_ABORT) begin
					s_nxt.err = 1'b1;
					s_nxt.run = 1'b0;
					s_nxt.st = ST_IDLE;
				end else begin
					s_nxt.st = ST_WBACK;
				end
			end
			ST_WBACK: begin
				// Only the top byte of word 0 is written
				s_nxt.req.valid = 1'b1;
				s_nxt.req.write = 1'b1;
				s_nxt.req.addr = {s_r.dptr_hi, s_r.dptr_lo};
				s_nxt.req.be = STS_BYTE_EN;
				// Whole top byte is written, so its other bits keep their fetched value
				s_nxt.req.data = {s_r.w0[31:29], DESCRIPTOR_STATUS_FIELD_DONE, s_r.w0[26:0]};
				if (s_r.req.valid && mem_ready) begin
					s_nxt.req.valid = 1'b0;
					if (s_r.w0[IOF_BIT]) begin
						s_nxt.fin = 1'b1;
					end
					s_nxt.st = ST_NEXT;
				end
			end
			ST_NEXT: begin
				if ({s_r.next_hi, s_r.next_lo} != '0 && !s_r.w0[LST_BIT]) begin
					s_nxt.dptr_lo = s_r.next_lo;
					s_nxt.dptr_hi = s_r.next_hi;
					s_nxt.st = ST_FETCH;
				end else if (chain_ok(s_r.cfg[CFG_NCL_BIT], s_r.cfg[CFG_NCH_BIT], s_nxt.nptr_lo, s_nxt.nptr_hi)) begin
					s_nxt.dptr_lo = s_nxt.nptr_lo;
					s_nxt.dptr_hi = s_nxt.nptr_hi;
					s_nxt.nptr_lo = '0;
					s_nxt.nptr_hi = '0;
					s_nxt.chain = 1'b1;
					s_nxt.st = ST_FETCH;
				end else begin
					s_nxt.halt = 1'b1;
					s_nxt.run = 1'b0;
					s_nxt.st = ST_IDLE;
				end
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
	end

	// ==========================================
	// Register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '{st: ST_IDLE, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wb_ack_o = s_r.ack;
	assign wb_err_o = s_r.bus_err;
	assign wb_dat_o = s_r.rdata;
	assign mem_req = s_r.req;

endmodule

// *** bench/host_mem_model.sv ***
`timescale 1ns/1ns
module host_mem_model
	import desc_walker_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic slow, // Half-rate answers
	input wire mem_req_s mem_req, // Request from walker
	output logic mem_ready, // Request taken
	output mem_rsp_s mem_rsp // Read words
);
	logic [31:0] mem [logic [63:0]];
	logic [63:0] base;
	int left;
	logic ph;
	// Busy while a read streams; every other cycle when slow
	assign mem_ready = (left == 0) && (!slow || ph);
	// Stream 8 words per read; idle data toggles so it is never stale
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{ph, left, mem_rsp} <= '0;
		end else begin
			ph <= !ph;
			mem_rsp <= {1'b0, ~mem_rsp.data};
			if (left > 0 && (!slow || ph)) begin
				mem_rsp <= {1'b1, mem[base]};
				base <= base + 64'h4;
				left <= left - 1;
			end
			if (mem_req.valid && mem_ready && !mem_req.write) begin
				base <= mem_req.addr;
				left <= 8;
			end
			if (mem_req.valid && mem_ready && mem_req.write && mem_req.be[3]) begin
				mem[mem_req.addr][31:24] <= mem_req.data[31:24];
			end
		end
	end
endmodule

// *** bench/desc_walker_chk.sv ***
`timescale 1ns/1ns
module desc_walker_chk
	import desc_walker_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_ack_o, // Acknowledge
	input wire logic wb_err_o, // Unmapped
	input wire mem_req_s mem_req, // Memory request
	input wire logic mem_ready // Request taken
);
	logic [63:0] rd_r;
	wire rd_go = mem_req.valid && mem_ready && !mem_req.write;
	// Address of the last descriptor fetch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) rd_r <= '0;
		else if (rd_go) rd_r <= mem_req.addr;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========================================
	// Memory side
	chk_wb_lane: assert property (mem_req.valid && mem_req.write |-> mem_req.be == STS_BYTE_EN
		&& mem_req.data[28:27] == DESCRIPTOR_STATUS_FIELD_DONE) else $error("bad write-back lanes");
	chk_wb_addr: assert property (mem_req.valid && mem_req.write |-> mem_req.addr == rd_r)
		else $error("write-back address");
	chk_req_hold: assert property (mem_req.valid && !mem_ready |=> mem_req.valid && $stable(mem_req))
		else $error("request changed");
	chk_one_desc: assert property (rd_go |=> !mem_req.valid [*8])
		else $error("request during fetch");
	chk_wr_gap: assert property (mem_req.valid && mem_ready && mem_req.write |=> !mem_req.valid)
		else $error("no gap after write-back");
	chk_addr_align: assert property (mem_req.valid |-> mem_req.addr[1:0] == 2'h0)
		else $error("unaligned address");
	// ==========================================
	// Register bus
	chk_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o != wb_err_o)
		else $error("bus not answered");
	chk_bus_pulse: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
		else $error("answer held");
endmodule
bind desc_walker desc_walker_chk desc_walker_chk_inst (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .mem_req(mem_req), .mem_ready(mem_ready));

// *** bench/tb.sv ***
`timescale 1ns/1ns
module tb;
	import desc_walker_pkg::*;
	logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, slow = 1, ack, err, mrdy, bad;
	logic [3:0] sel = 4'h0, sts_m = 4'h0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, rdat, q, seed = 32'he6f6;
	logic [63:0] nptr_m, lastp;
	logic [5:0] cfg_m;
	logic [64:0] exp_q [$];
	logic [31:0] img [logic [63:0]];
	int failures = 0, checks_done = 0, ticks = 0;
	mem_req_s mreq;
	mem_rsp_s mrsp;
	always #5 clk = ~clk;
	desc_walker desc_walker_inst (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
		.mem_req(mreq), .mem_ready(mrdy), .mem_rsp(mrsp));
	host_mem_model host_mem_model_inst (.clk(clk), .rst_n(rst_n), .slow(slow), .mem_req(mreq),
		.mem_ready(mrdy), .mem_rsp(mrsp));
	// ==========================================
	// Helpers
	task automatic check(input logic [64:0] seen, input logic [64:0] want);
		checks_done++;
		if (seen !== want) begin
			failures++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic end_sim();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Classic single cycle, held until the acknowledge or error edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		{cyc, stb, we, sel, adr, dat} <= {2'h3, w, 4'hf, a, d};
		do @(posedge clk); while (!(ack || err));
		q = rdat;
		bad = err;
		{cyc, stb} <= 2'h0;
		@(posedge clk);
	endtask
	// Descriptor into memory: flags word, random payload, next pointer
	task automatic put(input logic [63:0] p, input logic [31:0] w0, input logic [31:0] n);
		img[p] = w0;
		for (int k = 1; k < 8; k++) img[p + 4 * k] = (k == 6) ? n : (k == 7) ? 32'h0 : rnd();
		for (int k = 0; k < 8; k++) host_mem_model_inst.mem[p + 4 * k] = img[p + 4 * k];
	endtask
	// Reference walk: queue of expected fetches and write-backs
	function automatic void walk(logic [63:0] p);
		logic [31:0] w;
		logic [63:0] n;
		for (int k = 0; k < 8; k++) begin
			w = img[p];
			n = {img[p + 28], img[p + 24]};
			lastp = p;
			exp_q.push_back({1'b0, p});
			if (w[28:27] != 0 && cfg_m[5:4] == POL_SKIP) begin
				p = n;
				continue;
			end
			if (w[28:27] != 0 && cfg_m[5:4] == POL_ABORT) begin
				sts_m[STS_ERR_BIT] = 1;
				return;
			end
			exp_q.push_back({1'b1, p});
			img[p][28:27] = DESCRIPTOR_STATUS_FIELD_DONE;
			if (w[IOF_BIT]) sts_m[STS_FIN_BIT] = 1;
			if (n != 0 && !w[LST_BIT]) p = n;
			else if ((!cfg_m[3] && nptr_m[63:32] != 0) || (!cfg_m[2] && nptr_m[31:0] != 0)) begin
				p = nptr_m;
				nptr_m = 0;
				sts_m[STS_CHAIN_BIT] = 1;
			end else begin
				sts_m[STS_HALT_BIT] = 1;
				return;
			end
		end
	endfunction
	task automatic settle();
		q = 0;
		for (int i = 0; i < 60 && !(q[STS_HALT_BIT] || q[STS_ERR_BIT]); i++) wb(0, STS_ADDR, 0);
	endtask
	task automatic done_case(input int n);
		settle();
		check(q[3:0], sts_m);
		wb(0, CTL_ADDR, 0);
		check(q[CTL_RUN_BIT], 0);
		check(exp_q.size(), 0);
		wb(1, STS_ADDR, 32'hf);
		sts_m = 0;
		slow <= rnd() > 32'h80000000;
		$display("case %0d done", n);
	endtask
	// Cut a hang short
	always @(posedge clk) begin
		ticks++;
		if (ticks == 20000) begin
			failures++;
			end_sim();
		end
	end
	// Every accepted memory request against the reference queue
	always @(posedge clk) begin
		if (mreq.valid && mrdy) check({mreq.write, mreq.addr}, exp_q.size() ? exp_q.pop_front() : '1);
	end
	// ==========================================
	// Scenarios
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1;
		wb(1, CFG_ADDR, 0);
		cfg_m = 0;
		put(32'h100, 0, 32'h200);
		put(32'h200, 0, 0);
		put(32'h300, 32'h0c000000, 0);
		nptr_m = 32'h300;
		walk(32'h100);
		wb(1, DPTRH_ADDR, 0);
		wb(1, DPTRL_ADDR, 32'h100);
		wb(1, NPTRL_ADDR, 32'h300);
		wb(0, CTL_ADDR, 0);
		check(q[CTL_RUN_BIT], 1);
		done_case(1);
		walk(lastp);
		wb(1, CTL_ADDR, 1);
		done_case(2);
		wb(1, CFG_ADDR, 32'h1c);
		cfg_m = 6'h1c;
		put(32'h400, 32'h08000000, 32'h500);
		put(32'h500, 32'h02000000, 32'h600);
		nptr_m = 32'h600;
		walk(32'h400);
		wb(1, DPTRL_ADDR, 32'h400);
		wb(1, NPTRL_ADDR, 32'h600);
		done_case(3);
		wb(1, CFG_ADDR, 32'h04);
		cfg_m = 6'h04;
		walk(lastp);
		wb(1, CTL_ADDR, 1);
		done_case(4);
		wb(1, CFG_ADDR, 32'h21);
		cfg_m = 6'h21;
		put(64'h100000400, 32'h08000000, 0);
		walk(64'h100000400);
		wb(1, DPTRL_ADDR, 32'h400);
		wb(1, DPTRH_ADDR, 32'h1);
		settle();
		wb(1, CTL_ADDR, 1);
		done_case(5);
		wb(1, CFG_ADDR, 0);
		cfg_m = 0;
		put(32'h600, 32'h04000000, 0);
		sts_m[STS_CHAIN_BIT] = 1;
		nptr_m = 0;
		walk(32'h600);
		wb(1, NPTRL_ADDR, 32'h600);
		done_case(6);
		wb(0, NPTRL_ADDR, 0);
		check(q, 0);
		wb(0, DPTRL_ADDR, 0);
		check(q, 32'h600);
		wb(0, 8'h3c, 0);
		check(bad, 1);
		end_sim();
	end
endmodule
